// [hw/dpc_i2c_host.sv]
// two-wire bus master that drives a quad digipot, ordered over apb
// Behaviour
// R1: pin high and control bit set: normal
// R2: bytes shift most significant bit first
// R3: master moves data only while clock low
// R4: device releases data line after power-up
// R5: device ignores bus until start seen
// R6: stop ends every transaction, device standby
// R7: sender releases data, receiver acks ninth
// R8: device acks id, address, written data
// R9: master acks read bytes to continue
// R10: id is 1010, select pins, direction
// R11: direction bit one reads, zero writes
// R12: write: start, id, address, data, stop
// R13: device pointer advances, wraps after 08h
// R14: nv write after stop; wait 20ms
// R15: read: address written, repeated start, id read
// R16: master ends read with nack, stop
// R17: read data from pointer, wraps after 08h
// R18: check write-pending clear before nv readback
// R19: bank select bit picks volatile or not; the device model keeps one copy for both banks
// R20: nv wiper write also updates volatile
// R21: write-pending blocks wiper and control writes
// R22: unmatched id unacked, bus ignored
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_i2c_host #(
  parameter int unsigned QTR_CYC = (`DPC_TQ_NS + `DPC_CLK_NS - 1) / `DPC_CLK_NS,
  parameter int unsigned NV_WAIT_CYC = `DPC_TWC_MS * (`DPC_NS_PER_MS / `DPC_CLK_NS)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire dpc_pkg::dpc_apb_req_t apb_req,
  output dpc_pkg::dpc_apb_rsp_t apb_rsp,
  // serial clock, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // serial data, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // device power-down pin, high for normal operation
  output logic power_down_ctl
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dpc_pkg::dpc_state_t r;     // registered state
  dpc_pkg::dpc_state_t n;     // next state
  logic tick;                 // quarter-bit pulse
  logic adv;                  // quarter advances this cycle
  logic stall;                // device holds the clock low
  logic scl_s;                // synchronised clock line
  logic sda_s;                // synchronised data line
  logic setup;                // apb setup cycle
  logic acc;                  // apb access cycle
  logic mapped;               // address decodes
  logic wr;                   // write takes effect
  logic start_req;            // accepted go
  logic tx;                   // host sends the byte on the wire
  logic byte_end;             // ninth bit finishes
  logic nak_ev;               // device refused a byte
  localparam logic [`DPC_HOLD_W-1:0] HOLD_LOAD = `DPC_HOLD_W'(NV_WAIT_CYC - 1);

  // refuse a holdoff the counter cannot hold
  if (NV_WAIT_CYC < 1 || NV_WAIT_CYC >= (1 << `DPC_HOLD_W)) begin : g_bad_wait
    $error("dpc_i2c_host: NV_WAIT_CYC out of range");
  end

  // ----------------------------------------------------------------
  // pin synchronisers and quarter timing
  // ----------------------------------------------------------------
  dpc_sync #(
    .W(2)
  ) u_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .din({scl_i, sda_i}),
    .dout({scl_s, sda_s})
  );

  // divider restarts with each transaction so the first quarter is whole
  dpc_tick #(
    .QTR_CYC(QTR_CYC)
  ) u_tick (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clr(r.ph == dpc_pkg::ph_idle || r.ph == dpc_pkg::ph_hold),
    .tick(tick)
  );

  // open-drain pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = !r.scl_lo;
  assign sda_oe_n = !r.sda_lo;
  assign power_down_ctl = r.pd; // R1

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    setup = apb_req.psel && !apb_req.penable;
    acc = apb_req.psel && apb_req.penable;
    start_req = 1'b0;
    // decode
    unique case (apb_req.paddr)
      `DPC_OFS_CTRL, `DPC_OFS_XFER, `DPC_OFS_WDATA,
      `DPC_OFS_RDATA, `DPC_OFS_STAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    wr = acc && apb_req.pwrite && mapped;
    // read data is captured in the setup cycle, so the slave never waits
    if (setup) begin
      n.prdata = '0;
      unique case (apb_req.paddr)
        `DPC_OFS_CTRL: begin
          n.prdata[`DPC_CTRL_RD] = r.rd;
          n.prdata[`DPC_CTRL_SEL_HI:`DPC_CTRL_SEL_LO] = r.sel;
          n.prdata[`DPC_CTRL_PD] = r.pd;
        end
        `DPC_OFS_XFER: begin
          n.prdata[`DPC_XFER_RA_HI:0] = r.ra;
          n.prdata[`DPC_XFER_LEN_HI:`DPC_XFER_LEN_LO] = r.len;
        end
        `DPC_OFS_WDATA: n.prdata = r.wbuf;
        `DPC_OFS_RDATA: n.prdata = r.rbuf;
        `DPC_OFS_STAT: begin
          n.prdata[`DPC_STAT_BUSY] = (r.ph != dpc_pkg::ph_idle);
          n.prdata[`DPC_STAT_DONE] = r.done;
          n.prdata[`DPC_STAT_NACK] = r.nack;
          n.prdata[`DPC_STAT_PD] = r.pd;
        end
        default: n.prdata = '0;
      endcase
    end
    // register writes
    if (wr && apb_req.paddr == `DPC_OFS_CTRL) begin
      n.pd = apb_req.pwdata[`DPC_CTRL_PD];
      // direction and select stay fixed while a transaction runs
      if (r.ph == dpc_pkg::ph_idle) begin
        n.rd = apb_req.pwdata[`DPC_CTRL_RD];
        n.sel = apb_req.pwdata[`DPC_CTRL_SEL_HI:`DPC_CTRL_SEL_LO];
        start_req = apb_req.pwdata[`DPC_CTRL_GO];
      end
    end
    if (wr && apb_req.paddr == `DPC_OFS_XFER && r.ph == dpc_pkg::ph_idle) begin
      n.ra = apb_req.pwdata[`DPC_XFER_RA_HI:0];
      n.len = apb_req.pwdata[`DPC_XFER_LEN_HI:`DPC_XFER_LEN_LO];
    end
    if (wr && apb_req.paddr == `DPC_OFS_WDATA && r.ph == dpc_pkg::ph_idle) begin
      n.wbuf = apb_req.pwdata;
    end
    // write one to clear; the engine below sets afterwards and so wins
    if (wr && apb_req.paddr == `DPC_OFS_STAT) begin
      if (apb_req.pwdata[`DPC_STAT_DONE]) begin
        n.done = 1'b0;
      end
      if (apb_req.pwdata[`DPC_STAT_NACK]) begin
        n.nack = 1'b0;
      end
    end
    // engine helpers
    stall = !r.scl_lo && !scl_s && (r.q == 2'h1 || r.q == `DPC_Q_SAMPLE);
    adv = tick && !stall;
    tx = (r.step != dpc_pkg::st_dr);
    byte_end = (r.ph == dpc_pkg::ph_bit) && adv && (r.q == `DPC_Q_LAST) &&
               (r.bit_i == `DPC_ACK_BIT);
    nak_ev = byte_end && tx && r.nak;
    // bus engine
    unique case (r.ph)
      dpc_pkg::ph_idle: begin
        if (start_req) begin
          n.ph = dpc_pkg::ph_start;
          n.step = dpc_pkg::st_idw;
          n.q = '0;
          n.bit_i = '0;
          n.idx = '0;
          n.sh = {`DPC_ID_PREFIX, n.sel, 1'b0}; // R10 R11 R12
        end
      end
      dpc_pkg::ph_start: begin
        if (adv) begin
          n.q = r.q + 2'h1;
          if (r.q == `DPC_Q_LAST) begin
            n.ph = dpc_pkg::ph_bit;
          end
        end
      end
      dpc_pkg::ph_bit: begin
        if (adv) begin
          n.q = r.q + 2'h1;
          // sample at the end of the high clock, just before it falls
          if (r.q == `DPC_Q_SAMPLE) begin
            if (r.bit_i == `DPC_ACK_BIT) begin
              n.nak = sda_s;
            end else if (!tx) begin
              n.sh = {r.sh[6:0], sda_s}; // R2
            end
          end
          if (r.q == `DPC_Q_LAST) begin
            if (r.bit_i != `DPC_ACK_BIT) begin
              n.bit_i = r.bit_i + 4'h1;
              if (tx) begin
                n.sh = {r.sh[6:0], 1'b1}; // R2
              end
            end else begin
              n.bit_i = '0;
              if (tx && r.nak) begin
                // refused byte: stop at once
                n.nack = 1'b1; // R22
                n.ph = dpc_pkg::ph_stop;
              end else begin
                unique case (r.step)
                  dpc_pkg::st_idw: begin
                    n.step = dpc_pkg::st_ra;
                    n.sh = r.ra;
                  end
                  dpc_pkg::st_ra: begin
                    if (r.rd) begin
                      // repeated start then id with read direction
                      n.ph = dpc_pkg::ph_start; // R15
                      n.step = dpc_pkg::st_idr;
                      n.sh = {`DPC_ID_PREFIX, r.sel, 1'b1}; // R11
                    end else begin
                      n.step = dpc_pkg::st_dw;
                      n.sh = r.wbuf[7:0];
                    end
                  end
                  dpc_pkg::st_dw: begin
                    if (r.idx == r.len) begin
                      n.ph = dpc_pkg::ph_stop; // R12
                    end else begin
                      n.idx = r.idx + 2'h1;
                      n.sh = r.wbuf[{n.idx, 3'h0} +: 8];
                    end
                  end
                  dpc_pkg::st_idr: begin
                    n.step = dpc_pkg::st_dr;
                    n.sh = '1;
                  end
                  dpc_pkg::st_dr: begin
                    n.rbuf[{r.idx, 3'h0} +: 8] = r.sh;
                    if (r.idx == r.len) begin
                      n.ph = dpc_pkg::ph_stop; // R16
                    end else begin
                      n.idx = r.idx + 2'h1;
                    end
                  end
                  default: n.ph = dpc_pkg::ph_stop;
                endcase
              end
            end
          end
        end
      end
      dpc_pkg::ph_stop: begin
        if (adv) begin
          n.q = r.q + 2'h1;
          if (r.q == `DPC_Q_LAST) begin
            n.done = 1'b1; // R6
            // any write that reached the data phase may start an nv cycle
            if (r.step == dpc_pkg::st_dw) begin
              n.ph = dpc_pkg::ph_hold; // R14
              n.hold = HOLD_LOAD;
            end else begin
              n.ph = dpc_pkg::ph_idle;
            end
          end
        end
      end
      dpc_pkg::ph_hold: begin
        // nv write time; go is refused meanwhile and busy stays set,
        // so software sees the pending store before any readback
        if (r.hold == '0) begin // R18
          n.ph = dpc_pkg::ph_idle; // R14
        end else begin
          n.hold = r.hold - `DPC_HOLD_W'(1);
        end
      end
      default: n.ph = dpc_pkg::ph_idle;
    endcase
    // pin drive follows the next phase and quarter
    n.scl_lo = 1'b0;
    n.sda_lo = 1'b0;
    unique case (n.ph)
      dpc_pkg::ph_start: begin
        n.scl_lo = (n.q == 2'h0) || (n.q == `DPC_Q_LAST);
        n.sda_lo = (n.q >= `DPC_Q_SAMPLE);
      end
      dpc_pkg::ph_bit: begin
        // data moves only in quarter 0, with the clock held low
        n.scl_lo = (n.q == 2'h0) || (n.q == `DPC_Q_LAST); // R3
        if (n.bit_i == `DPC_ACK_BIT) begin
          // release for the device ack, or ack/nack a read byte
          n.sda_lo = (n.step == dpc_pkg::st_dr) && (n.idx != n.len); // R7 R9 R16
        end else begin
          n.sda_lo = (n.step != dpc_pkg::st_dr) && !n.sh[7]; // R2
        end
      end
      dpc_pkg::ph_stop: begin
        n.scl_lo = (n.q == 2'h0);
        n.sda_lo = (n.q <= 2'h1); // R6
      end
      default: begin
        n.scl_lo = 1'b0;
        n.sda_lo = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.ph <= dpc_pkg::ph_idle;
      r.step <= dpc_pkg::st_idw;
      r.sel <= `DPC_SEL_RST;
      r.pd <= `DPC_PD_RST;
    end else begin
      r <= n;
    end
  end

  // apb answer: zero wait states
  always_comb begin
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = acc && !mapped;
    apb_rsp.prdata = r.prdata;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  chk_sda_clock_low: assert property ( // R3
    $changed(sda_oe_n) && scl_oe_n |-> (r.ph == dpc_pkg::ph_start || r.ph == dpc_pkg::ph_stop))
    else $error("data line moved while clock high outside start or stop");
  chk_id_match: assert property ( // R10
    r.ph == dpc_pkg::ph_bit && r.bit_i == '0 &&
    (r.step == dpc_pkg::st_idw || r.step == dpc_pkg::st_idr) |->
    r.sh[7:1] == {`DPC_ID_PREFIX, r.sel})
    else $error("id byte does not carry prefix and select");
  chk_dir_bit: assert property ( // R11
    r.ph == dpc_pkg::ph_bit && r.bit_i == '0 &&
    (r.step == dpc_pkg::st_idw || r.step == dpc_pkg::st_idr) |->
    r.sh[0] == (r.step == dpc_pkg::st_idr))
    else $error("direction bit wrong");
  chk_msb_first: assert property ( // R2
    r.ph == dpc_pkg::ph_bit && r.q == 2'h1 && r.bit_i != `DPC_ACK_BIT &&
    r.step != dpc_pkg::st_dr |-> sda_oe_n == r.sh[7])
    else $error("sent bit is not the top of the shifter");
  chk_release_ack: assert property ( // R7
    r.ph == dpc_pkg::ph_bit && r.bit_i == `DPC_ACK_BIT &&
    r.step != dpc_pkg::st_dr |-> sda_oe_n)
    else $error("host drove data line in device ack slot");
  chk_last_nack: assert property ( // R16
    r.ph == dpc_pkg::ph_bit && r.bit_i == `DPC_ACK_BIT &&
    r.step == dpc_pkg::st_dr |-> sda_oe_n == (r.idx == r.len))
    else $error("read ack or nack wrong for byte position");
  chk_nack_stop: assert property ( // R22
    nak_ev |=> r.ph == dpc_pkg::ph_stop && r.nack)
    else $error("refused byte did not lead to stop");
  chk_stop_end: assert property ( // R6
    r.ph == dpc_pkg::ph_stop && n.ph != dpc_pkg::ph_stop |=>
    (r.ph == dpc_pkg::ph_idle || r.ph == dpc_pkg::ph_hold) && r.done && scl_oe_n && sda_oe_n)
    else $error("stop did not end in released bus");
  chk_hold_wait: assert property ( // R14
    r.ph == dpc_pkg::ph_hold && r.hold != '0 |=>
    r.ph == dpc_pkg::ph_hold && r.hold == $past(r.hold) - `DPC_HOLD_W'(1))
    else $error("nv holdoff cut short");
  chk_repeat_start: assert property ( // R15
    byte_end && !r.nak && r.step == dpc_pkg::st_ra && r.rd |=>
    r.ph == dpc_pkg::ph_start && r.step == dpc_pkg::st_idr)
    else $error("read lacks repeated start");

  cov_write_done: cover property (r.ph == dpc_pkg::ph_stop ##1 r.ph == dpc_pkg::ph_hold);
  cov_read_done: cover property (byte_end && r.step == dpc_pkg::st_dr && r.idx == r.len);
  cov_nack: cover property (nak_ev);
  cov_stretch: cover property (stall && tick);
endmodule
`default_nettype wire

// [hw/dpc_pkg.sv]
// types shared by the digipot i2c host modules
package dpc_pkg;
  // bus engine phase
  typedef enum logic [2:0] {ph_idle, ph_start, ph_bit, ph_stop, ph_hold} dpc_phase_t;
  // which byte of the transaction is on the wire
  typedef enum logic [2:0] {st_idw, st_ra, st_dw, st_idr, st_dr} dpc_step_t;
  // apb request from the bus master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } dpc_apb_req_t;
  // apb answer to the bus master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dpc_apb_rsp_t;
  // whole state of the host
  typedef struct packed {
    dpc_phase_t ph;
    dpc_step_t step;
    logic [1:0] q;
    logic [3:0] bit_i;
    logic [7:0] sh;
    logic nak;
    logic [1:0] idx;
    logic [1:0] len;
    logic rd;
    logic [2:0] sel;
    logic pd;
    logic [7:0] ra;
    logic [31:0] wbuf;
    logic [31:0] rbuf;
    logic done;
    logic nack;
    logic [21:0] hold;
    logic scl_lo;
    logic sda_lo;
    logic [31:0] prdata;
  } dpc_state_t;
  // quarter-bit divider state
  typedef struct packed {
    logic [7:0] cnt;
  } dpc_div_t;
endpackage

// [hw/dpc_regs.svh]
// register offsets, field positions, reset values and timing of the digipot i2c host
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH
// ----------------------------------------------------------------
// apb register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define DPC_OFS_CTRL 8'h00
`define DPC_OFS_XFER 8'h04
`define DPC_OFS_WDATA 8'h08
`define DPC_OFS_RDATA 8'h0c
`define DPC_OFS_STAT 8'h10
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DPC_CTRL_GO 0
`define DPC_CTRL_RD 1
`define DPC_CTRL_SEL_LO 2
`define DPC_CTRL_SEL_HI 4
`define DPC_CTRL_PD 5
`define DPC_XFER_RA_HI 7
`define DPC_XFER_LEN_LO 8
`define DPC_XFER_LEN_HI 9
`define DPC_STAT_BUSY 0
`define DPC_STAT_DONE 1
`define DPC_STAT_NACK 2
`define DPC_STAT_PD 3
// ----------------------------------------------------------------
// reset values and protocol constants
// ----------------------------------------------------------------
`define DPC_SEL_RST 3'h0
`define DPC_PD_RST 1'b1
`define DPC_ID_PREFIX 4'ha
`define DPC_ACK_BIT 4'h8
`define DPC_Q_SAMPLE 2'h2
`define DPC_Q_LAST 2'h3
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DPC_CLK_NS 10
`define DPC_TQ_NS 625
`define DPC_TWC_MS 20
`define DPC_NS_PER_MS 1000000
`define DPC_HOLD_W 22
`define DPC_DIV_W 8
`endif

// [hw/dpc_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dpc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // first stage is read only by the second
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] dout_nxt;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    meta_nxt = din;
    dout_nxt = meta_r;
  end

  // ----------------------------------------------------------------
  // registers; pins idle high through pull-ups
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= '1;
      dout <= '1;
    end else begin
      meta_r <= meta_nxt;
      dout <= dout_nxt;
    end
  end
endmodule
`default_nettype wire

// [hw/dpc_tick.sv]
// quarter-bit tick generator that makes the serial clock timing
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_tick #(
  parameter int unsigned QTR_CYC = 63
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // hold the divider at zero while the bus is idle
  input wire logic clr,
  // one-cycle pulse at each quarter-bit end
  output logic tick
);
  dpc_pkg::dpc_div_t r_r;
  dpc_pkg::dpc_div_t r_nxt;
  localparam logic [`DPC_DIV_W-1:0] LAST = `DPC_DIV_W'(QTR_CYC - 1);

  // refuse quarters the counter cannot hold
  if (QTR_CYC < 2 || QTR_CYC >= (1 << `DPC_DIV_W)) begin : g_bad_qtr
    $error("dpc_tick: QTR_CYC out of range");
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    tick = !clr && (r_r.cnt == LAST);
    if (clr || tick) begin
      r_nxt.cnt = '0;
    end else begin
      r_nxt.cnt = r_r.cnt + `DPC_DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule
`default_nettype wire

// [verif/dpc_dev_model.sv]
// behavioural quad digipot slave standing on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module dpc_dev_model #(
  parameter int WIP_NS = 200
) (
  // bus wires
  input wire logic scl,
  input wire logic sda,
  // select pins and power-down pin
  input wire logic [2:0] sel,
  input wire logic power_down_ctl,
  // data driver, low pulls the wire
  output logic sda_oe_n,
  output logic shut_down
);
  logic [7:0] mem [0:8]; // wipers, spare, access_control_reg at 8
  logic [7:0] sh, ptr, dbyte;
  logic [3:0] cnt; // posedges seen in this byte, 9 = ack slot done
  logic [1:0] ph; // 0 id, 1 address, 2 data
  logic act, tx, mack, wrote;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[8] = 8'h40; // bank select 0, power-down bit 1
    {act, tx, wrote, mack} = 4'h0;
    {cnt, ph} = 6'h00;
    sda_oe_n = 1'b1; // released after power-up
  end
  assign shut_down = !(power_down_ctl && mem[8][6]);
  function automatic logic [7:0] nx(input logic [7:0] p);
    return (p == 8'h08) ? 8'h00 : p + 8'h01;
  endfunction
  // start or repeated start: only now does the bus count
  always @(negedge sda) if (scl) begin
    {act, tx, cnt, ph} = {1'b1, 1'b0, 4'h0, 2'h0};
  end
  // stop: standby, and a write kicks the self-timed store
  always @(posedge sda) if (scl) begin
    {act, tx, sda_oe_n} = 3'b001;
    if (wrote) begin
      mem[8][5] = 1'b1;
      mem[8][5] <= #(WIP_NS) 1'b0;
    end
    wrote = 1'b0;
  end
  // bits taken on the rising clock, msb first
  always @(posedge scl) if (act) begin
    if (cnt < 8) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
    end else begin
      mack = !sda; // master ack decides whether to go on
      cnt = 4'h9;
    end
  end
  // drive on the falling clock only, so no false start or stop
  always @(negedge scl) if (act) begin
    if (cnt == 8 && !tx) begin
      sda_oe_n = 1'b0; // ack the received byte
      if (ph == 2'h0) begin
        if (sh[7:1] != {4'ha, sel}) begin
          act = 1'b0;
          sda_oe_n = 1'b1;
        end
        tx = sh[0];
      end else if (ph == 2'h1) ptr = sh;
      else begin
        if (!mem[8][5]) begin // refused while store pending
          if (ptr == 8'h08) mem[8][7:6] = sh[7:6];
          else mem[ptr] = sh; // one copy serves both banks
          wrote = 1'b1;
        end
        ptr = nx(ptr);
      end
    end else if (cnt == 8) sda_oe_n = 1'b1; // sender lets go
    else if (cnt == 9) begin
      cnt = 4'h0;
      sda_oe_n = 1'b1;
      if (tx && ph == 2'h2 && !mack) act = 1'b0;
      else if (tx) begin
        dbyte = (ptr == 8'h08) ? {mem[8][7:5], 5'h00} : mem[ptr];
        ptr = nx(ptr);
        sda_oe_n = dbyte[7];
      end
      ph = (tx || ph == 2'h2) ? 2'h2 : ph + 2'h1;
    end else if (tx && cnt != 0) sda_oe_n = dbyte[4'h7 - cnt[2:0]];
  end
endmodule
`default_nettype wire

// [verif/dpc_i2c_host_tb.sv]
// self-checking bench of the digipot host against the device model
`timescale 1ns/1ps
`default_nettype none
`include "dpc_regs.svh"
module dpc_i2c_host_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  dpc_pkg::dpc_apb_req_t req = '0;
  dpc_pkg::dpc_apb_rsp_t rsp;
  wire logic scl_oe_n, sda_oe_n, dev_oe_n, pd_pin, shut;
  wire logic scl = scl_oe_n; // pull-up, only the host drives it
  wire logic sda = sda_oe_n & dev_oe_n; // open drain with pull-up
  logic [2:0] pins = 3'h0;
  logic [31:0] rnd = 32'd87313;
  logic [31:0] q, d;
  logic [7:0] shad [0:8]; // expected device contents
  logic [7:0] a, p;
  logic [2:0] s;
  logic [1:0] l;
  logic e;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  dpc_i2c_host #(.QTR_CYC(4), .NV_WAIT_CYC(50)) dut (.core_clk(core_clk), .reset_n(reset_n),
    .apb_req(req), .apb_rsp(rsp), .scl_i(scl), .scl_o(), .scl_oe_n(scl_oe_n), .sda_i(sda),
    .sda_o(), .sda_oe_n(sda_oe_n), .power_down_ctl(pd_pin));
  dpc_dev_model dev (.scl(scl), .sda(sda), .sel(pins), .power_down_ctl(pd_pin),
    .sda_oe_n(dev_oe_n), .shut_down(shut));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] nx(input logic [7:0] v);
    return (v == 8'h08) ? 8'h00 : v + 8'h01;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_mem(input logic [7:0] exp, input logic [7:0] got);
    chk("device byte", {24'h0, exp}, {24'h0, got});
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    req <= {1'b1, 1'b0, w, ad, wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    while (rsp.pready !== 1'b1) @(posedge core_clk);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask
  // program one transaction, wait for idle, check and clear status
  task automatic xfer(input logic r, input logic [2:0] st);
    int n;
    n = 0;
    apb(1'b1, `DPC_OFS_XFER, {22'h0, l, a});
    apb(1'b1, `DPC_OFS_WDATA, d);
    apb(1'b1, `DPC_OFS_CTRL, {26'h0, 1'b1, s, r, 1'b1});
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 3000) begin
      apb(1'b0, `DPC_OFS_STAT, 32'h0);
      n++;
    end
    chk("status", {29'h0, st}, {29'h0, q[2:0]});
    chk("idle wires", 32'h3, {30'h0, scl, sda});
    apb(1'b1, `DPC_OFS_STAT, 32'h6);
  endtask
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    foreach (shad[i]) shad[i] = 8'h00;
    shad[8] = 8'h40;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("pd pin", 32'h1, {31'h0, pd_pin});
    apb(1'b0, `DPC_OFS_CTRL, 32'h0);
    chk("ctrl", 32'h20, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    apb(1'b1, `DPC_OFS_CTRL, 32'h0);
    chk("shutdown", 32'h1, {31'h0, shut});
    apb(1'b1, `DPC_OFS_CTRL, 32'h20);
    chk("shutdown", 32'h0, {31'h0, shut});
    // random transfers with the wrap corners first
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      d = lfsr(rnd);
      s = rnd[2:0];
      a = (k == 0) ? 8'h07 : (k == 1) ? 8'h08 : {4'h0, rnd[11:8]} % 8'h09;
      l = (k == 0) ? 2'h3 : rnd[13:12];
      pins <= s;
      xfer(1'b0, 3'h2);
      p = a;
      for (int i = 0; i <= l; i++) begin
        if (p == 8'h08) shad[8][7:6] = d[8*i+6 +: 2];
        else shad[p] = d[8*i +: 8];
        chk_mem(shad[p], dev.mem[p]);
        p = nx(p);
      end
      xfer(1'b1, 3'h2);
      apb(1'b0, `DPC_OFS_RDATA, 32'h0);
      p = a;
      for (int i = 0; i <= l; i++) begin
        chk("read byte", {24'h0, shad[p]}, {24'h0, q[8*i +: 8]});
        p = nx(p);
      end
    end
    // wrong select pins: no ack, nothing written
    pins <= 3'h5;
    s = 3'h2;
    a = 8'h01;
    l = 2'h0;
    d = ~{24'h0, shad[1]};
    xfer(1'b0, 3'h6);
    chk_mem(shad[1], dev.mem[1]);
    tally_and_finish;
  end
endmodule
`default_nettype wire
